/* hw/pfs_pkg.sv */
package pfs_pkg;
  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;       // Clock period at 100 MHz
  localparam int OC_DELAY_NS        = 50;       // Overcurrent response delay
  localparam int OC_DELAY_CYC       = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOPE_WINDOW_NS    = 30;       // Slope discrimination window
  localparam int SLOPE_WINDOW_CYC   = (SLOPE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_RESET_NS        = 350000;   // Input-low time that clears short latch
  localparam int SC_RESET_CYC       = (SC_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_NS           = 200;      // Ideal-diode blanking after input fall
  localparam int BLANK_CYC          = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W              = 20;       // Width of timing counters

  // ----------------------------------------------------------------------
  // Ideal-diode states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_IDM_BLANK   = 2'b00,  // Off, waiting for blank time
    PFS_IDM_MONITOR = 2'b01,  // Off, watching for negative drain
    PFS_IDM_CONDUCT = 2'b10   // On, conducting third-quadrant current
  } pfs_idm_type;
endpackage : pfs_pkg

/* hw/pfs_delay_timer.sv */
// Counts consecutive cycles of a level; done when it reached the limit
module pfs_delay_timer #(
  parameter int unsigned LIMIT = 4
) (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic level_in,   // Level being timed
  output logic      done_out    // Level held for LIMIT cycles
);
  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [pfs_pkg::CNT_W-1:0] cnt_q;   // Cycles seen so far
  logic [pfs_pkg::CNT_W-1:0] cnt_d;   // Next count
  localparam logic [pfs_pkg::CNT_W-1:0] LIM = pfs_pkg::CNT_W'(LIMIT);

  // Saturating count while level holds, clear otherwise
  always_comb begin
    if (!level_in) begin
      cnt_d = '0;
    end else if (cnt_q < LIM) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Register the count
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = level_in && (cnt_q >= LIM);
endmodule : pfs_delay_timer

/* hw/pfs_supervisor.sv */
// Contract
// - Overcurrent turns switch off after delay, unlatched
// - Overcurrent clears when switch input falls
// - Delayed overcurrent versus short: short wins only within the slope window
// - Short turns off with reduced drive
// - Short latches off until long input low
// - Transistor overtemp enters ideal-diode operation
// - Driver overtemp disables regulator, converter, switch
// - Driver overtemp suppresses ideal-diode operation
// - Fault low on either overtemp state
// - Release fault after both sensors cool
// - Driver cools, transistor hot: back to diode
// - Undervoltage holds switch off, fault low
// - Regulators enable on lockout rise, off when bias falls to about 5 V to 6 V
// - Open drive pin while monitored: off, fault
// - Open pin gone: resume, release fault
// - Fault encoding across both fault outputs
// - Pin shorted to aux at power-up stops monitoring
// - Temperature output high during transistor overtemp
// - Input fall forces off, starts blanking
module pfs_supervisor (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic switch_in,              // Switch command from controller (pin)
  input  wire logic oc_cmp_in,              // Current above overcurrent threshold
  input  wire logic sc_cmp_in,              // Current above short-circuit threshold
  input  wire logic fet_hot_in,             // Transistor sensor above upper trip
  input  wire logic fet_cool_in,            // Transistor sensor below lower trip
  input  wire logic drv_hot_in,             // Driver sensor above upper trip
  input  wire logic drv_cool_in,            // Driver sensor below lower trip
  input  wire logic supply_ok_in,           // Bias above lockout threshold
  input  wire logic supply_low_in,          // Bias fell to about 5 V to 6 V
  input  wire logic drive_pin_open_in,      // Drive-strength pin above range
  input  wire logic drive_pin_aux_in,       // Drive-strength pin shorted to aux rail
  input  wire logic drain_negative_in,      // Drain voltage negative
  input  wire logic both_outputs_en_in,     // Report on both fault outputs
  output logic      gate_on_out,            // Power transistor gate enable
  output logic      slow_turnoff_out,       // Reduced drive strength on turn-off
  output logic      aux_regulator_en_out,   // Aux regulator and negative rail enable
  output logic      fault_out_n,            // Active-low fault output
  output logic      overcurrent_flag_out_n, // Active-low overcurrent output
  output logic      temp_flag_out           // Temperature output forced high
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NS = 12;                   // Number of synchronised pins
  logic [NS-1:0] raw;                       // Raw pin vector
  logic [NS-1:0] s1_q;                      // First stage
  logic [NS-1:0] s2_q;                      // Second stage, safe to use
  assign raw = {switch_in, oc_cmp_in, sc_cmp_in, fet_hot_in, fet_cool_in, drv_hot_in,
                drv_cool_in, supply_ok_in, supply_low_in, drive_pin_open_in,
                drive_pin_aux_in, drain_negative_in};

  // Two-flop synchroniser for every pin except both_outputs_en_in
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic sw, oc, sc, fhot, fcool, dhot, dcool, uv_ok, uv_low, pin_open, pin_aux, dneg;
  assign {sw, oc, sc, fhot, fcool, dhot, dcool, uv_ok, uv_low, pin_open, pin_aux,
          dneg} = s2_q;

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  logic oc_win_done;   // Overcurrent held for slope window
  logic oc_del_done;   // Overcurrent held for response delay
  logic sw_low_done;   // Input held low for latch reset
  logic blank_done;    // Blanking since input fall expired
  logic blank_run;     // Blank timer level

  pfs_delay_timer #(.LIMIT(pfs_pkg::SLOPE_WINDOW_CYC)) u_win (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .level_in(oc), .done_out(oc_win_done));
  pfs_delay_timer #(.LIMIT(pfs_pkg::OC_DELAY_CYC)) u_del (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .level_in(oc), .done_out(oc_del_done));
  pfs_delay_timer #(.LIMIT(pfs_pkg::SC_RESET_CYC)) u_rst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .level_in(!sw), .done_out(sw_low_done));
  pfs_delay_timer #(.LIMIT(pfs_pkg::BLANK_CYC)) u_blk (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .level_in(blank_run),
    .done_out(blank_done));

  // ----------------------------------------------------------------------
  // Fault state
  // ----------------------------------------------------------------------
  logic oc_q, oc_d;            // Cycle-by-cycle overcurrent
  logic sc_q, sc_d;            // Latched short circuit
  logic fot_q, fot_d;          // Transistor overtemp
  logic dot_q, dot_d;          // Driver overtemp
  logic mon_q, mon_d;          // Drive pin monitored
  logic strap_q, strap_d;      // Strap sampled once
  logic ldo_q, ldo_d;          // Regulators enabled
  logic sw_q;                  // Previous input, for edge detect
  pfs_pkg::pfs_idm_type idm_q, idm_d;
  logic sw_fall;
  assign sw_fall = sw_q && !sw;

  // Next-state for all fault flags; set has priority over clear, except the regulator enable, where off wins
  always_comb begin
    oc_d    = oc_q;
    sc_d    = sc_q;
    fot_d   = fot_q;
    dot_d   = dot_q;
    mon_d   = mon_q;
    strap_d = strap_q;
    ldo_d   = ldo_q;
    // Short wins when its comparator beats the windowed overcurrent
    if (sc && !oc_win_done && !oc_q) begin
      sc_d = 1'b1;
    end else if (sc_q && sw_low_done) begin
      sc_d = 1'b0;
    end
    if (oc_del_done && !sc_d) begin
      oc_d = 1'b1;
    end else if (!sw) begin
      oc_d = 1'b0;
    end
    if (fhot) begin
      fot_d = 1'b1;
    end else if (fcool) begin
      fot_d = 1'b0;
    end
    if (dhot) begin
      dot_d = 1'b1;
    end else if (dcool) begin
      dot_d = 1'b0;
    end
    // Strap checked once, first cycle with good supply
    if (!strap_q && uv_ok) begin
      strap_d = 1'b1;
      mon_d   = !pin_aux;
    end
    // Regulators on at lockout rise, off near 5 V to 6 V or driver hot
    // Held off through the cycle the driver flag clears, so the restart is not early
    if (uv_low || dot_q || dot_d) begin
      ldo_d = 1'b0;
    end else if (uv_ok) begin
      ldo_d = 1'b1;
    end
  end

  // Ideal-diode sequence, restarted on every input fall
  always_comb begin
    idm_d = idm_q;
    unique case (idm_q)
      pfs_pkg::PFS_IDM_BLANK:   if (blank_done) idm_d = pfs_pkg::PFS_IDM_MONITOR;
      pfs_pkg::PFS_IDM_MONITOR: if (dneg) idm_d = pfs_pkg::PFS_IDM_CONDUCT;
      pfs_pkg::PFS_IDM_CONDUCT: if (!dneg) idm_d = pfs_pkg::PFS_IDM_MONITOR;
      default:                  idm_d = pfs_pkg::PFS_IDM_MONITOR;
    endcase
    if (!fot_q || dot_q) begin
      idm_d = pfs_pkg::PFS_IDM_MONITOR;
    end
    if (sw_fall) begin
      idm_d = pfs_pkg::PFS_IDM_BLANK;
    end
  end
  assign blank_run = (idm_q == pfs_pkg::PFS_IDM_BLANK) && !sw_fall;

  // Register all fault state
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      oc_q    <= 1'b0;
      sc_q    <= 1'b0;
      fot_q   <= 1'b0;
      dot_q   <= 1'b0;
      mon_q   <= 1'b0;
      strap_q <= 1'b0;
      ldo_q   <= 1'b0;
      sw_q    <= 1'b0;
      idm_q   <= pfs_pkg::PFS_IDM_MONITOR;
    end else begin
      oc_q    <= oc_d;
      sc_q    <= sc_d;
      fot_q   <= fot_d;
      dot_q   <= dot_d;
      mon_q   <= mon_d;
      strap_q <= strap_d;
      ldo_q   <= ldo_d;
      sw_q    <= sw;
      idm_q   <= idm_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic uvlo, open_fault, temp_fault, gate_d, slow_d, flt_d, ocf_d;
  logic gate_q, slow_q, flt_q, ocf_q;
  assign uvlo       = !uv_ok;
  assign open_fault = mon_q && pin_open;
  assign temp_fault = fot_q || dot_q;

  // Gate and flag decode; any blocking fault keeps the switch off
  always_comb begin
    if (uvlo || sc_q || oc_q || dot_q || open_fault) begin
      gate_d = 1'b0;
    end else if (fot_q) begin
      gate_d = (idm_q == pfs_pkg::PFS_IDM_CONDUCT);
    end else begin
      gate_d = sw;
    end
    slow_d = sc_q;
    flt_d  = !(uvlo || temp_fault || open_fault || sc_q ||
               (oc_q && !both_outputs_en_in));
    ocf_d  = !(both_outputs_en_in && (oc_q || sc_q));
  end

  // Register outputs
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      gate_q <= 1'b0;
      slow_q <= 1'b0;
      flt_q  <= 1'b0;
      ocf_q  <= 1'b1;
    end else begin
      gate_q <= gate_d;
      slow_q <= slow_d;
      flt_q  <= flt_d;
      ocf_q  <= ocf_d;
    end
  end

  assign gate_on_out            = gate_q;
  assign slow_turnoff_out       = slow_q;
  assign fault_out_n            = flt_q;
  assign overcurrent_flag_out_n = ocf_q;
  assign aux_regulator_en_out   = ldo_q;
  assign temp_flag_out          = fot_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_sc_gate_off;
    @(posedge ref_clk_in) disable iff (reset_in) sc_q |=> !gate_on_out;
  endproperty
  a_sc_gate_off: assert property (p_sc_gate_off) else $error("gate on in short");

  property p_sc_slow;
    @(posedge ref_clk_in) disable iff (reset_in) sc_q |=> slow_turnoff_out;
  endproperty
  a_sc_slow: assert property (p_sc_slow) else $error("short not slow");

  property p_oc_clear;
    @(posedge ref_clk_in) disable iff (reset_in) (oc_q && !sw && !oc_del_done) |=> !oc_q;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent stuck");

  property p_oc_off;
    @(posedge ref_clk_in) disable iff (reset_in) oc_q |=> !gate_on_out;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("gate on in overcurrent");

  property p_temp_fault;
    @(posedge ref_clk_in) disable iff (reset_in) temp_fault |=> !fault_out_n;
  endproperty
  a_temp_fault: assert property (p_temp_fault) else $error("fault not low");

  property p_drv_off;
    @(posedge ref_clk_in) disable iff (reset_in) dot_q |=> (!gate_on_out && !aux_regulator_en_out);
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver hot yet on");

  property p_uvlo;
    @(posedge ref_clk_in) disable iff (reset_in) uvlo |=> (!gate_on_out && !fault_out_n);
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout not held");

  property p_open;
    @(posedge ref_clk_in) disable iff (reset_in) open_fault |=> (!gate_on_out && !fault_out_n);
  endproperty
  a_open: assert property (p_open) else $error("open pin not held");

  property p_fall;
    @(posedge ref_clk_in) disable iff (reset_in)
      sw_fall |=> (idm_q == pfs_pkg::PFS_IDM_BLANK) ##1 !gate_on_out;
  endproperty
  a_fall: assert property (p_fall) else $error("fall did not blank");

  property p_oc_enc;
    @(posedge ref_clk_in) disable iff (reset_in)
      (oc_q && !sc_q && both_outputs_en_in) |=> !overcurrent_flag_out_n;
  endproperty
  a_oc_enc: assert property (p_oc_enc) else $error("overcurrent not shown");
endmodule : pfs_supervisor

/* dv/pfs_pwm_ctrl.sv */
// ----------------------------------------------------------------------
// Controller model: drives the switch command pin
// ----------------------------------------------------------------------
module pfs_pwm_ctrl (
  input  wire logic ref_clk_in, // Bench clock
  input  wire logic pwm_in,     // Requested switch level
  output logic      switch_out  // Switch command pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pwm_q; // Requested level taken at the rising edge

  // Known low levels from time zero
  initial begin
    pwm_q      = 1'b0;
    switch_out = 1'b0;
  end

  // Take the request on the rising edge, so a falling-edge update never races
  always @(posedge ref_clk_in) begin
    pwm_q <= pwm_in;
  end

  // Level changes land away from the sampling edge; long lows clear a short latch
  always @(negedge ref_clk_in) begin
    switch_out <= pwm_q;
  end
endmodule : pfs_pwm_ctrl

/* dv/pfs_supervisor_tb.sv */
// ----------------------------------------------------------------------
// Compare and bounded wait helpers
// ----------------------------------------------------------------------
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAITC(c, n) begin for (w = 0; w < (n) && !(c); w++) @(negedge ref_clk_in); \
  `CHK((c), 1'b1) if (!(c)) finish_test(); end

module pfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and controls
  logic ref_clk_in = 1'b0, reset_in = 1'b1, pwm = 1'b0;
  // Comparator and sensor levels, idle values
  logic oc = 1'b0, sc = 1'b0, fet_hot = 1'b0, fet_cool = 1'b1;
  logic drv_hot = 1'b0, drv_cool = 1'b1, ok = 1'b0, low = 1'b0;
  logic open = 1'b0, aux = 1'b0, neg = 1'b0, both = 1'b1;
  // Design outputs
  logic switch_w, gate, slow, reg_en, fault_n, oc_n, temp;
  int   miscompares = 0, checked = 0, w;

  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;

  // Far-side controller
  pfs_pwm_ctrl u_ctrl (.ref_clk_in(ref_clk_in), .pwm_in(pwm), .switch_out(switch_w));

  pfs_supervisor u_dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .switch_in(switch_w),
    .oc_cmp_in(oc), .sc_cmp_in(sc), .fet_hot_in(fet_hot), .fet_cool_in(fet_cool),
    .drv_hot_in(drv_hot), .drv_cool_in(drv_cool), .supply_ok_in(ok),
    .supply_low_in(low), .drive_pin_open_in(open), .drive_pin_aux_in(aux),
    .drain_negative_in(neg), .both_outputs_en_in(both), .gate_on_out(gate),
    .slow_turnoff_out(slow), .aux_regulator_en_out(reg_en), .fault_out_n(fault_n),
    .overcurrent_flag_out_n(oc_n), .temp_flag_out(temp));

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Three-edge pin-to-output latency plus margin
  task settle;
    repeat (5) @(negedge ref_clk_in);
  endtask : settle

  // Lockout holds off, regulator follows supply
  task t_uvlo;
    pwm = 1'b1;
    settle();
    `CHK(gate, 1'b0)
    `CHK(fault_n, 1'b0)
    ok = 1'b1;
    `WAITC(reg_en, 16)
    `WAITC(gate & fault_n, 16)
    ok = 1'b0;
    low = 1'b1;
    `WAITC(!reg_en, 16)
    `CHK(gate, 1'b0)
    low = 1'b0;
    ok = 1'b1;
    `WAITC(gate, 16)
    $display("test uvlo done");
  endtask : t_uvlo

  // Cycle-by-cycle overcurrent, both reporting modes
  task t_oc;
    oc = 1'b1;
    `WAITC(!gate, 32)
    `CHK({oc_n, fault_n, slow}, 3'b010)
    pwm = 1'b0;
    oc = 1'b0;
    settle();
    pwm = 1'b1;
    `WAITC(gate, 16)
    `CHK(oc_n, 1'b1)
    both = 1'b0;
    oc = 1'b1;
    `WAITC(!gate, 32)
    `CHK({oc_n, fault_n}, 2'b10)
    pwm = 1'b0;
    oc = 1'b0;
    both = 1'b1;
    settle();
    $display("test overcurrent done");
  endtask : t_oc

  // Fast slope latches a short until a long low input
  task t_sc;
    pwm = 1'b1;
    `WAITC(gate, 16)
    oc = 1'b1;
    sc = 1'b1;
    `WAITC(!gate, 32)
    `CHK(slow, 1'b1)
    `CHK({oc_n, fault_n}, 2'b00)
    oc = 1'b0;
    sc = 1'b0;
    pwm = 1'b0;
    settle();
    pwm = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    `CHK(gate, 1'b0)
    pwm = 1'b0;
    `WAITC(!slow, 36000)
    pwm = 1'b1;
    `WAITC(gate, 16)
    `CHK(fault_n, 1'b1)
    pwm = 1'b0;
    $display("test short done");
  endtask : t_sc

  // Two-level thermal shutdown with ideal-diode conduction
  task t_temp;
    fet_cool = 1'b0;
    fet_hot = 1'b1;
    `WAITC(!fault_n, 16)
    `CHK(temp, 1'b1)
    neg = 1'b1;
    `WAITC(gate, 40)
    pwm = 1'b1;
    settle();
    pwm = 1'b0;
    settle();
    `CHK(gate, 1'b0)
    `WAITC(gate, 40)
    `CHK(w >= pfs_pkg::BLANK_CYC - 6, 1'b1)
    drv_cool = 1'b0;
    drv_hot = 1'b1;
    `WAITC(!reg_en, 16)
    settle();
    `CHK(gate, 1'b0)
    drv_hot = 1'b0;
    drv_cool = 1'b1;
    `WAITC(gate, 40)
    `CHK(fault_n, 1'b0)
    neg = 1'b0;
    fet_hot = 1'b0;
    settle();
    `CHK(fault_n, 1'b0)
    fet_cool = 1'b1;
    `WAITC(fault_n, 16)
    `CHK(temp, 1'b0)
    pwm = 1'b1;
    `WAITC(gate, 16)
    $display("test thermal done");
  endtask : t_temp

  // Open drive pin, then strap to aux disables monitoring
  task t_pin;
    open = 1'b1;
    `WAITC(!gate, 16)
    `CHK(fault_n, 1'b0)
    open = 1'b0;
    `WAITC(gate, 16)
    `CHK(fault_n, 1'b1)
    reset_in = 1'b1;
    aux = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    reset_in = 1'b0;
    `WAITC(gate, 32)
    open = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    `CHK({gate, fault_n}, 2'b11)
    $display("test drive pin done");
  endtask : t_pin

  // ----------------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (3) @(negedge ref_clk_in);
    reset_in = 1'b0;
    `CHK({gate, slow, reg_en, oc_n}, 4'b0001)
    t_uvlo();
    t_oc();
    t_sc();
    t_temp();
    t_pin();
    finish_test();
  end
endmodule : pfs_supervisor_tb
